/* verilog/timer8_pkg.sv */
// What this block does
// - Tick select zero stops the timer
// - Counter always readable and writable by software
// - Counter write beats count or clear
// - Each tick clears, increments or decrements the counter
// - Three-bit waveform mode split over two controls
// - Overflow flag set per mode, can request interrupt
// - Counter compared against both compare values always
// - Match sets compare flag one tick later
// - Flag cleared by service or writing one
// - PWM modes buffer compare writes, others direct
// - Buffered value loads only on a tick at top
// - Compare address reaches buffer or active register
// - Force strobe acts like match without flag, in non-PWM modes only
// - Counter write blocks matches on next tick
// - Compare output kept across modes, reset zero
// - Output action takes effect at next match
// - Nonzero action overrides port data, direction stays
// - Action zero leaves compare output untouched
// - Action field never changes the count sequence
// - Bottom zero, max all ones, top per mode
// - Normal mode wraps and sets overflow together
package timer8_pkg;
	localparam logic [7:0] OFS_CONTROL_A = 8'h00;
	localparam logic [7:0] OFS_CONTROL_B = 8'h04;
	localparam logic [7:0] OFS_COUNTER   = 8'h08;
	localparam logic [7:0] OFS_COMPARE_A = 8'h0c;
	localparam logic [7:0] OFS_COMPARE_B = 8'h10;
	localparam logic [7:0] OFS_FLAGS     = 8'h14;
	localparam logic [7:0] OFS_ENABLES   = 8'h18;

	localparam logic [7:0] RESET_BYTE   = 8'h00;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] COUNT_MAX    = 8'hff;

	localparam logic [2:0] TICK_STOPPED  = 3'h0;
	localparam logic [2:0] TICK_DIV1     = 3'h1;
	localparam logic [2:0] TICK_DIV8     = 3'h2;
	localparam logic [2:0] TICK_DIV64    = 3'h3;
	localparam logic [2:0] TICK_DIV256   = 3'h4;
	localparam logic [2:0] TICK_DIV1024  = 3'h5;
	localparam logic [2:0] TICK_EXT_FALL = 3'h6;
	localparam logic [2:0] TICK_EXT_RISE = 3'h7;

	localparam logic [2:0] MODE_NORMAL   = 3'h0;
	localparam logic [2:0] MODE_CTC      = 3'h2;
	localparam logic [2:0] MODE_PC_CMP   = 3'h5;
	localparam logic [2:0] MODE_FAST_CMP = 3'h7;

	localparam logic [1:0] ACTION_NONE   = 2'h0;
	localparam logic [1:0] ACTION_TOGGLE = 2'h1;
	localparam logic [1:0] ACTION_CLEAR  = 2'h2;
	localparam logic [1:0] ACTION_SET    = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] action_a;
		logic [1:0] action_b;
		logic [1:0] unused;
		logic [1:0] wave_low;
	} control_a_t;

	typedef struct packed {
		logic       force_a;
		logic       force_b;
		logic [1:0] unused;
		logic       wave_high;
		logic [2:0] tick_source_select;
	} control_b_t;

	typedef struct packed {
		logic cmp_b;
		logic cmp_a;
		logic overflow;
	} event_t;
endpackage

/* verilog/timer8_counter_compare_output.sv */
`timescale 1ns/1ns
module timer8_counter_compare_output
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        ext_tick_pin,
	input  wire logic [2:0]  irq_ack,
	output logic [2:0]       irq_req,
	input  wire logic [1:0]  port_data,
	input  wire logic [1:0]  output_pin_direction_bit,
	output logic [1:0]       pin_out,
	output logic [1:0]       pin_oe,
	output logic [1:0]       compare_output
);
	timer8_pkg::control_a_t timer_control_a;
	timer8_pkg::control_b_t timer_control_b;
	timer8_pkg::event_t     flags;
	timer8_pkg::event_t     enables;
	timer8_pkg::event_t     set_ev;
	logic [7:0]       counter_value;
	logic [1:0][7:0]  cmp_active;
	logic [1:0][7:0]  cmp_buffer;
	logic [7:0]       next_count;
	logic [7:0]       top;
	logic [2:0]       waveform_mode_field;
	logic [9:0]       prescale;
	logic             ext_prev;
	logic             tick;
	logic             tick_eff;
	logic             count_down;
	logic             block_match;
	logic             pwm;
	logic             fast;
	logic             phase;
	logic             at_top;
	logic             update_point;
	logic [1:0]       match;
	logic [1:0]       event_match;
	logic [1:0]       force_ev;
	logic             aw_held;
	logic             w_held;
	logic [7:0]       aw_addr;
	logic [31:0]      w_data;
	logic [3:0]       w_strb;
	logic             wr_go;
	logic             counter_wr;
	logic [1:0]       cmp_wr;
	logic             ctl_b_wr;
	logic [7:0]       rd_byte;
	logic             rd_hit;

	assign waveform_mode_field = {timer_control_b.wave_high, timer_control_a.wave_low};
	assign pwm   = waveform_mode_field[0];
	assign fast  = waveform_mode_field[1:0] == 2'h3;
	assign phase = waveform_mode_field[1:0] == 2'h1;
	assign top = (waveform_mode_field == timer8_pkg::MODE_CTC || waveform_mode_field == timer8_pkg::MODE_PC_CMP
		|| waveform_mode_field == timer8_pkg::MODE_FAST_CMP) ? cmp_active[0] : timer8_pkg::COUNT_MAX;
	assign at_top = counter_value == top;

	// Bus slave: address and data accepted in either order
	assign awready = !aw_held;
	assign wready  = !w_held;
	assign arready = !rvalid;
	assign wr_go   = aw_held && w_held && !bvalid;
	assign counter_wr = wr_go && w_strb[0] && aw_addr == timer8_pkg::OFS_COUNTER;
	assign cmp_wr[0]  = wr_go && w_strb[0] && aw_addr == timer8_pkg::OFS_COMPARE_A;
	assign cmp_wr[1]  = wr_go && w_strb[0] && aw_addr == timer8_pkg::OFS_COMPARE_B;
	assign ctl_b_wr   = wr_go && w_strb[0] && aw_addr == timer8_pkg::OFS_CONTROL_B;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= timer8_pkg::RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (wr_go)
			begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= (aw_addr <= timer8_pkg::OFS_ENABLES && aw_addr[1:0] == 2'h0)
					? timer8_pkg::RESP_OKAY : timer8_pkg::RESP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	always_comb
	begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		case (araddr)
			timer8_pkg::OFS_CONTROL_A: rd_byte = timer_control_a;
			timer8_pkg::OFS_CONTROL_B: rd_byte = {2'h0, timer_control_b[5:0]};
			timer8_pkg::OFS_COUNTER:   rd_byte = counter_value;
			timer8_pkg::OFS_COMPARE_A: rd_byte = pwm ? cmp_buffer[0] : cmp_active[0];
			timer8_pkg::OFS_COMPARE_B: rd_byte = pwm ? cmp_buffer[1] : cmp_active[1];
			timer8_pkg::OFS_FLAGS:     rd_byte = {5'h00, flags};
			timer8_pkg::OFS_ENABLES:   rd_byte = {5'h00, enables};
			default:                   rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= timer8_pkg::RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata  <= {24'h00_0000, rd_byte};
			rresp  <= rd_hit ? timer8_pkg::RESP_OKAY : timer8_pkg::RESP_SLVERR;
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
	end

	// Control registers; force bits are strobes and never stored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_control_a <= timer8_pkg::RESET_BYTE;
			timer_control_b <= timer8_pkg::RESET_BYTE;
			enables         <= 3'h0;
		end
		else
		begin
			if (wr_go && w_strb[0] && aw_addr == timer8_pkg::OFS_CONTROL_A)
				timer_control_a <= w_data[7:0];
			if (ctl_b_wr)
				timer_control_b <= {2'h0, w_data[5:0]};
			if (wr_go && w_strb[0] && aw_addr == timer8_pkg::OFS_ENABLES)
				enables <= w_data[2:0];
		end
	end

	// Shared prescaler runs freely; external pin is edge detected
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prescale <= 10'h000;
			ext_prev <= 1'b0;
		end
		else
		begin
			prescale <= prescale + 10'h001;
			ext_prev <= ext_tick_pin;
		end
	end

	always_comb
	begin
		case (timer_control_b.tick_source_select)
			timer8_pkg::TICK_STOPPED:  tick = 1'b0;
			timer8_pkg::TICK_DIV1:     tick = 1'b1;
			timer8_pkg::TICK_DIV8:     tick = &prescale[2:0];
			timer8_pkg::TICK_DIV64:    tick = &prescale[5:0];
			timer8_pkg::TICK_DIV256:   tick = &prescale[7:0];
			timer8_pkg::TICK_DIV1024:  tick = &prescale;
			timer8_pkg::TICK_EXT_FALL: tick = ext_prev && !ext_tick_pin;
			timer8_pkg::TICK_EXT_RISE: tick = !ext_prev && ext_tick_pin;
			default:                   tick = 1'b0;
		endcase
	end
	// A colliding counter write discards the tick entirely
	assign tick_eff = tick && !counter_wr;

	// Count sequence depends only on the waveform mode and, as top, compare A
	always_comb
	begin
		next_count = counter_value + 8'h01;
		if (phase)
		begin
			if (!count_down && at_top)
				next_count = counter_value - 8'h01;
			else if (count_down && counter_value != timer8_pkg::COUNT_BOTTOM)
				next_count = counter_value - 8'h01;
		end
		else if ((fast || waveform_mode_field == timer8_pkg::MODE_CTC) && at_top)
			next_count = timer8_pkg::COUNT_BOTTOM;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			counter_value <= timer8_pkg::COUNT_BOTTOM;
		else if (counter_wr)
			counter_value <= w_data[7:0];
		else if (tick_eff)
			counter_value <= next_count;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_down <= 1'b0;
		else if (!phase)
			count_down <= 1'b0;
		else if (tick_eff && !count_down && at_top)
			count_down <= 1'b1;
		else if (tick_eff && count_down && counter_value == timer8_pkg::COUNT_BOTTOM)
			count_down <= 1'b0;
	end

	// Stays armed through a stopped timer until the next tick
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			block_match <= 1'b0;
		else if (counter_wr)
			block_match <= 1'b1;
		else if (tick)
			block_match <= 1'b0;
	end

	assign update_point = tick_eff && pwm && at_top;

	always_comb
	begin
		set_ev.overflow = tick_eff && (phase ? (count_down && counter_value == timer8_pkg::COUNT_BOTTOM)
			: fast ? at_top : counter_value == timer8_pkg::COUNT_MAX);
		set_ev.cmp_a = event_match[0];
		set_ev.cmp_b = event_match[1];
	end

	// Hardware set wins over a clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flags <= 3'h0;
		else if (wr_go && w_strb[0] && aw_addr == timer8_pkg::OFS_FLAGS)
			flags <= (flags & ~(w_data[2:0] | irq_ack)) | set_ev;
		else
			flags <= (flags & ~irq_ack) | set_ev;
	end
	assign irq_req = flags & enables;

	function automatic logic apply(input logic cur, input logic [1:0] act, input logic tog_ok, input logic lvl);
		case (act)
			timer8_pkg::ACTION_TOGGLE: apply = tog_ok ? !cur : cur;
			timer8_pkg::ACTION_CLEAR:  apply = lvl;
			timer8_pkg::ACTION_SET:    apply = !lvl;
			default:                   apply = cur;
		endcase
	endfunction

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			logic [1:0] act;
			logic       tog_ok;
			assign act    = (ch == 0) ? timer_control_a.action_a : timer_control_a.action_b;
			assign tog_ok = ch == 0 && (waveform_mode_field == timer8_pkg::MODE_FAST_CMP
				|| waveform_mode_field == timer8_pkg::MODE_PC_CMP);
			assign match[ch] = counter_value == cmp_active[ch];
			assign event_match[ch] = tick_eff && match[ch] && !block_match;
			assign force_ev[ch] = ctl_b_wr && !pwm && w_data[7 - ch];

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					cmp_active[ch] <= timer8_pkg::RESET_BYTE;
					cmp_buffer[ch] <= timer8_pkg::RESET_BYTE;
				end
				else
				begin
					if (cmp_wr[ch])
						cmp_buffer[ch] <= w_data[7:0];
					if (cmp_wr[ch] && !pwm)
						cmp_active[ch] <= w_data[7:0];
					else if (update_point)
						cmp_active[ch] <= cmp_buffer[ch];
				end
			end

			// Wrap action wins over a match landing on top, so no spike at restart
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					compare_output[ch] <= 1'b0;
				else if (!pwm)
				begin
					if (event_match[ch] || force_ev[ch])
						compare_output[ch] <= apply(compare_output[ch], act, 1'b1, 1'b0);
				end
				else if (fast)
				begin
					if (tick_eff && at_top)
						compare_output[ch] <= apply(compare_output[ch], act, 1'b0, 1'b1);
					else if (event_match[ch])
						compare_output[ch] <= apply(compare_output[ch], act, tog_ok, 1'b0);
				end
				else if (event_match[ch])
					compare_output[ch] <= apply(compare_output[ch], act, tog_ok, count_down);
			end

			assign pin_out[ch] = (act != timer8_pkg::ACTION_NONE) ? compare_output[ch] : port_data[ch];
			assign pin_oe[ch]  = output_pin_direction_bit[ch];
		end
	endgenerate

	a_stopped_counter_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		timer_control_b.tick_source_select == timer8_pkg::TICK_STOPPED && !counter_wr
		|=> counter_value == $past(counter_value))
		else $error("counter moved while stopped");

	a_write_beats_count: assert property (@(posedge aclk) disable iff (!aresetn)
		counter_wr |=> counter_value == $past(w_data[7:0]))
		else $error("counter write lost");

	a_normal_wrap_overflow: assert property (@(posedge aclk) disable iff (!aresetn)
		tick_eff && waveform_mode_field == timer8_pkg::MODE_NORMAL && counter_value == timer8_pkg::COUNT_MAX
		|=> counter_value == timer8_pkg::COUNT_BOTTOM && flags.overflow)
		else $error("normal wrap missed overflow");

	a_match_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		tick_eff && match[0] && !block_match |=> flags.cmp_a && irq_req[1] == enables.cmp_a)
		else $error("match did not set flag");

	a_blocked_match_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		block_match && tick && !counter_wr && !flags.cmp_a && !flags.cmp_b |=> !flags.cmp_a && !flags.cmp_b)
		else $error("match after counter write");

	a_direct_compare_write: assert property (@(posedge aclk) disable iff (!aresetn)
		cmp_wr[0] && !pwm |=> cmp_active[0] == $past(w_data[7:0]))
		else $error("direct compare write lost");

	a_buffer_holds_active: assert property (@(posedge aclk) disable iff (!aresetn)
		pwm && !update_point |=> $stable(cmp_active))
		else $error("active compare changed off top");

	a_force_toggles_output: assert property (@(posedge aclk) disable iff (!aresetn)
		force_ev[0] && timer_control_a.action_a == timer8_pkg::ACTION_TOGGLE && !set_ev.cmp_a && !flags.cmp_a
		|=> compare_output[0] != $past(compare_output[0]) && !flags.cmp_a)
		else $error("force strobe misbehaved");

	a_reset_clears_output: assert property (@(posedge aclk)
		!aresetn |=> compare_output == 2'h0)
		else $error("output not cleared by reset");

	a_action_none_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		timer_control_a.action_b == timer8_pkg::ACTION_NONE |=> compare_output[1] == $past(compare_output[1]))
		else $error("idle action changed output");

	a_ack_clears_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_ack[1] && !set_ev.cmp_a |=> !flags.cmp_a)
		else $error("serviced flag not cleared");
endmodule

/* verification/tb_timer8_counter_compare_output.sv */
`timescale 1ns/1ns
module tb_timer8_counter_compare_output;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h1;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	logic        ext_tick_pin = 1'b0;
	logic [2:0]  irq_ack = 3'h0;
	logic [2:0]  irq_req;
	logic [1:0]  port_data = 2'h0;
	logic [1:0]  dir_bits = 2'h0;
	logic [1:0]  pin_out;
	logic [1:0]  pin_oe;
	logic [1:0]  compare_output;
	logic [31:0] rd_val;
	logic [1:0]  rsp;
	logic [1:0]  m_oc = 2'h0;
	int          num_errors = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          m_cnt = 0, m_cmpa = 0, m_cmpb = 0, m_flags = 0, m_ens = 0, m_ca = 0, m_cb = 0, m_blk = 0;

	timer8_counter_compare_output dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_tick_pin(ext_tick_pin), .irq_ack(irq_ack),
		.irq_req(irq_req), .port_data(port_data), .output_pin_direction_bit(dir_bits), .pin_out(pin_out),
		.pin_oe(pin_oe), .compare_output(compare_output));

	always #25 aclk = ~aclk;

	task automatic wrap_up();
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Generous ceiling: the whole sequence needs under a thousand cycles
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic [2:0] exp, input logic [2:0] got);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	function automatic int mode();
		return ((m_cb >> 3) & 1) * 4 + (m_ca & 3);
	endfunction

	function automatic logic act(input int code, input logic cur);
		case (code)
			1: return ~cur;
			2: return 1'b0;
			3: return 1'b1;
			default: return cur;
		endcase
	endfunction

	// Register write that also keeps the reference model in step
	task automatic wr(input logic [7:0] a, input int d);
		axi_wr(a, 32'(d), rsp);
		chk_bit("write response", {1'b0, rsp}, {1'b0, timer8_pkg::RESP_OKAY});
		case (a)
			timer8_pkg::OFS_CONTROL_A: m_ca = d & 255;
			timer8_pkg::OFS_CONTROL_B:
			begin
				m_cb = d & 15;
				if (d[7] && mode() % 2 == 0)
					m_oc[0] = act((m_ca >> 6) & 3, m_oc[0]);
				if (d[6] && mode() % 2 == 0)
					m_oc[1] = act((m_ca >> 4) & 3, m_oc[1]);
			end
			timer8_pkg::OFS_COUNTER:
			begin
				m_cnt = d & 255;
				m_blk = 1;
			end
			timer8_pkg::OFS_COMPARE_A: m_cmpa = d & 255;
			timer8_pkg::OFS_COMPARE_B: m_cmpb = d & 255;
			timer8_pkg::OFS_FLAGS: m_flags = m_flags & ~d;
			timer8_pkg::OFS_ENABLES: m_ens = d & 7;
			default: ;
		endcase
	endtask

	// One full pulse on the external source; model follows non-PWM modes only
	task automatic tick();
		int nc;
		@(posedge aclk);
		ext_tick_pin <= 1'b1;
		repeat (4) @(posedge aclk);
		ext_tick_pin <= 1'b0;
		repeat (4) @(posedge aclk);
		if ((m_cb & 7) != 0 && mode() % 2 == 0)
		begin
			if (m_blk == 0 && m_cnt == m_cmpa)
			begin
				m_flags = m_flags | 2;
				m_oc[0] = act((m_ca >> 6) & 3, m_oc[0]);
			end
			if (m_blk == 0 && m_cnt == m_cmpb)
			begin
				m_flags = m_flags | 4;
				m_oc[1] = act((m_ca >> 4) & 3, m_oc[1]);
			end
			nc = (mode() == 2 && m_cnt == m_cmpa) ? 0 : (m_cnt + 1) % 256;
			if (m_cnt == 255)
				m_flags = m_flags | 1;
			m_cnt = nc;
			m_blk = 0;
		end
	endtask

	task automatic check_all();
		logic [1:0] po;
		port_data <= 2'($urandom);
		dir_bits <= 2'($urandom);
		axi_rd(timer8_pkg::OFS_COUNTER, rd_val, rsp);
		chk_reg("counter", 32'(m_cnt), rd_val);
		axi_rd(timer8_pkg::OFS_FLAGS, rd_val, rsp);
		chk_reg("flags", 32'(m_flags), rd_val);
		chk_bit("irq request", 3'(m_flags & m_ens), irq_req);
		chk_bit("compare output", {1'b0, m_oc}, {1'b0, compare_output});
		po[0] = ((m_ca >> 6) & 3) != 0 ? m_oc[0] : port_data[0];
		po[1] = ((m_ca >> 4) & 3) != 0 ? m_oc[1] : port_data[1];
		chk_bit("pin out", {1'b0, po}, {1'b0, pin_out});
		chk_bit("pin enable", {1'b0, dir_bits}, {1'b0, pin_oe});
	endtask

	initial
	begin
		void'($urandom(32'h7994));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		check_all();
		for (int a = 0; a < 32; a += 4)
		begin
			axi_rd(8'(a), rd_val, rsp);
			chk_reg("reset read", 32'h0, rd_val);
			chk_bit("read response", {1'b0, rsp}, (a == 28) ? 3'h2 : 3'h0);
		end
		axi_wr(8'h1c, 32'h5a, rsp);
		chk_bit("unmapped write response", {1'b0, rsp}, 3'h2);
		// Stopped source: ticks on the pin must not move the counter
		wr(timer8_pkg::OFS_COUNTER, $urandom_range(255));
		repeat (3) tick();
		check_all();
		wr(timer8_pkg::OFS_CONTROL_A, 8'h40);
		wr(timer8_pkg::OFS_CONTROL_B, 8'h07);
		wr(timer8_pkg::OFS_COMPARE_A, 8'h40);
		wr(timer8_pkg::OFS_COUNTER, 8'h40);
		tick();
		check_all();
		wr(timer8_pkg::OFS_COUNTER, 8'h3e);
		repeat (2) tick();
		check_all();
		tick();
		check_all();
		wr(timer8_pkg::OFS_ENABLES, 7);
		wr(timer8_pkg::OFS_COUNTER, 8'hfe);
		repeat (2) tick();
		check_all();
		@(posedge aclk);
		irq_ack <= 3'h2;
		@(posedge aclk);
		irq_ack <= 3'h0;
		m_flags = m_flags & ~2;
		check_all();
		wr(timer8_pkg::OFS_FLAGS, 0);
		check_all();
		wr(timer8_pkg::OFS_FLAGS, 1);
		check_all();
		for (int code = 0; code < 4; code++)
		begin
			wr(timer8_pkg::OFS_CONTROL_A, (code << 4) | (m_ca & 8'hc0));
			wr(timer8_pkg::OFS_COMPARE_B, 8'h10);
			wr(timer8_pkg::OFS_COUNTER, 8'h0e);
			repeat (3) tick();
			check_all();
		end
		wr(timer8_pkg::OFS_CONTROL_A, 8'he0);
		wr(timer8_pkg::OFS_CONTROL_B, 8'hc7);
		check_all();
		wr(timer8_pkg::OFS_CONTROL_A, 8'h40);
		// Falling-edge source from here on, so both pin edges get used
		wr(timer8_pkg::OFS_CONTROL_B, 8'hc6);
		check_all();
		wr(timer8_pkg::OFS_CONTROL_A, 8'h42);
		wr(timer8_pkg::OFS_COMPARE_A, 3);
		wr(timer8_pkg::OFS_COUNTER, 0);
		repeat (9)
		begin
			tick();
			check_all();
		end
		// Fast PWM: old compare value must stay active until top
		wr(timer8_pkg::OFS_CONTROL_A, 8'h00);
		wr(timer8_pkg::OFS_COMPARE_B, 2);
		wr(timer8_pkg::OFS_FLAGS, 7);
		wr(timer8_pkg::OFS_CONTROL_A, 8'h23);
		wr(timer8_pkg::OFS_COMPARE_B, 8'h80);
		axi_rd(timer8_pkg::OFS_COMPARE_B, rd_val, rsp);
		chk_reg("buffered compare", 32'h80, rd_val);
		wr(timer8_pkg::OFS_COUNTER, 0);
		repeat (3) tick();
		axi_rd(timer8_pkg::OFS_FLAGS, rd_val, rsp);
		chk_reg("flag b before load", 32'h4, rd_val & 32'h4);
		wr(timer8_pkg::OFS_FLAGS, 7);
		wr(timer8_pkg::OFS_COUNTER, 8'hfe);
		repeat (2) tick();
		chk_bit("pwm output at bottom", 3'h2, {1'b0, compare_output});
		wr(timer8_pkg::OFS_COUNTER, 8'h7e);
		repeat (3) tick();
		axi_rd(timer8_pkg::OFS_FLAGS, rd_val, rsp);
		chk_reg("flag b after load", 32'h4, rd_val & 32'h4);
		chk_bit("pwm output at match", 3'h0, {1'b0, compare_output});
		wr(timer8_pkg::OFS_CONTROL_A, 8'h00);
		wr(timer8_pkg::OFS_FLAGS, 7);
		wr(timer8_pkg::OFS_COUNTER, 8'h20);
		check_all();
		wrap_up();
	end
endmodule
